// ---- logic/rse_bit_set.sv ----
package rse_pkg;

  // core widths; plain defaults for this core
  localparam int unsigned PC_W        = 13;
  localparam int unsigned STACK_DEPTH = 8;
  localparam int unsigned SP_W        = 3;
  localparam int unsigned NIB_W       = 4;
  localparam int unsigned DPX_W       = 4;
  localparam int unsigned DPY_W       = 4;
  localparam int unsigned DPZ_W       = 2;
  localparam int unsigned ADDR_W      = 4;
  localparam int unsigned RDATA_W     = 32;

  // register map (byte offsets)
  localparam logic [ADDR_W-1:0] CTRL_OFF   = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFF = 4'h4;
  localparam logic [ADDR_W-1:0] RETCNT_OFF = 4'h8;

  // field positions
  localparam int unsigned CTRL_EN_BIT      = 0;
  localparam int unsigned STAT_SP_LSB      = 0;
  localparam int unsigned STAT_BUSY_BIT    = 4;
  localparam int unsigned STAT_SHADOW_BIT  = 5;
  localparam int unsigned RETCNT_W         = 8;

  // reset values
  localparam logic [SP_W-1:0]     SP_RST     = 3'h0;
  localparam logic                EN_RST     = 1'b1;
  localparam logic [RETCNT_W-1:0] RETCNT_RST = 8'h00;

  typedef enum logic [2:0] {
    RSE_OP_NONE        = 3'h0,
    RSE_OP_INT_RETURN  = 3'h1, // interrupt_return_op
    RSE_OP_RETURN_SKIP = 3'h2,
    RSE_OP_BIT_SET     = 3'h3, // memory_bit_set_op
    RSE_OP_CARRY_SET   = 3'h4  // carry_set_op
  } rse_op_e;

  typedef enum logic [1:0] {
    RSE_ST_IDLE = 2'b00,
    RSE_ST_RET2 = 2'b01
  } rse_state_e;

  typedef struct packed {
    logic              valid;
    rse_op_e           op;
    logic [NIB_W-1:0]  imm;
  } rse_instr_s;

  typedef struct packed {
    logic [DPX_W-1:0] dp_x;
    logic [DPY_W-1:0] dp_y;
    logic [DPZ_W-1:0] dp_z;
    logic             carry_flag;
    logic             skip;
    logic             nop_mode;
    logic [NIB_W-1:0] acc;
    logic [NIB_W-1:0] aux;
  } rse_ctx_s;

  typedef struct packed {
    logic [ADDR_W-1:0]  addr;
    logic [31:0]        wdata;
    logic               wr;
    logic               rd;
  } rse_bus_s;

endpackage

`timescale 1ns/1ps

module rse_bit_set (
  // nibble in
  input  wire logic [rse_pkg::NIB_W-1:0] nib_i,
  input  wire logic [1:0]                idx_i,
  // nibble out
  output logic      [rse_pkg::NIB_W-1:0] nib_o
);

  always_comb begin
    nib_o = nib_i;
    nib_o[idx_i] = 1'b1;
  end

endmodule // rse_bit_set

// ---- logic/rse_return_set_exec.sv ----
`timescale 1ns/1ps

module rse_return_set_exec (
  // clock and reset
  input  wire logic                        core_clk_i,
  input  wire logic                        rst_i,
  // instruction issue
  input  wire rse_pkg::rse_instr_s         instr_i,
  output logic                             instr_ready_o,
  // call push and interrupt entry
  input  wire logic                        push_i,
  input  wire logic [rse_pkg::PC_W-1:0]    push_pc_i,
  input  wire logic                        int_take_i,
  input  wire rse_pkg::rse_ctx_s           ctx_i,
  // program counter and skip
  output logic                             pc_load_o,
  output logic      [rse_pkg::PC_W-1:0]    pc_o,
  output logic                             skip_next_o,
  // context restore and carry
  output logic                             restore_o,
  output rse_pkg::rse_ctx_s                ctx_o,
  output logic                             carry_set_o,
  // data memory
  input  wire logic [9:0]                  dp_addr_i,
  input  wire logic [rse_pkg::NIB_W-1:0]   mem_rdata_i,
  output logic                             mem_wr_o,
  output logic      [9:0]                  mem_addr_o,
  output logic      [rse_pkg::NIB_W-1:0]   mem_wdata_o,
  // register port
  input  wire rse_pkg::rse_bus_s           bus_i,
  output logic      [31:0]                 bus_rdata_o
);

  typedef struct packed {
    rse_pkg::rse_state_e                                  st;
    logic [rse_pkg::SP_W-1:0]                             sp;
    logic [rse_pkg::STACK_DEPTH-1:0][rse_pkg::PC_W-1:0]   stk;
    rse_pkg::rse_ctx_s                                    shadow;
    logic                                                 shadow_vld;
    logic                                                 en;
    logic [rse_pkg::RETCNT_W-1:0]                         retcnt;
    logic                                                 pc_load;
    logic [rse_pkg::PC_W-1:0]                             pc;
    logic                                                 skip;
    logic                                                 restore;
    rse_pkg::rse_ctx_s                                    ctx;
    logic                                                 carry_set;
    logic                                                 mem_wr;
    logic [9:0]                                           mem_addr;
    logic [rse_pkg::NIB_W-1:0]                            mem_wdata;
    logic [31:0]                                          rdata;
  } rse_reg_s;

  rse_reg_s                    s_q;
  rse_reg_s                    s_d;
  logic                        take;
  logic [rse_pkg::NIB_W-1:0]   set_nib;

  assign instr_ready_o = (s_q.st == rse_pkg::RSE_ST_IDLE);
  assign take          = instr_i.valid && instr_ready_o && s_q.en;

  // bit index straight from the immediate field
  rse_bit_set u_bit_set (
    .nib_i (mem_rdata_i),
    .idx_i (instr_i.imm[1:0]),
    .nib_o (set_nib)
  );

  always_comb begin
    s_d           = s_q;
    s_d.pc_load   = 1'b0;
    s_d.skip      = 1'b0;
    s_d.restore   = 1'b0;
    s_d.carry_set = 1'b0;
    s_d.mem_wr    = 1'b0;
    s_d.rdata     = 32'h0000_0000;

    // a push in the same cycle as a return still writes its slot, but the return's pointer decrement wins
    // the pointer wraps, so nesting deeper than the stack loses the oldest
    if (push_i) begin
      s_d.sp = s_q.sp + 3'h1;
      s_d.stk[s_q.sp + 3'h1] = push_pc_i;
    end

    // snapshot for the interrupt return
    if (int_take_i) begin
      s_d.shadow     = ctx_i;
      s_d.shadow_vld = 1'b1;
    end

    case (s_q.st)
      rse_pkg::RSE_ST_IDLE: begin
        if (take) begin
          case (instr_i.op)
            rse_pkg::RSE_OP_INT_RETURN,
            rse_pkg::RSE_OP_RETURN_SKIP: begin
              s_d.pc_load = 1'b1;
              s_d.pc      = s_q.stk[s_q.sp];
              s_d.sp      = s_q.sp - 3'h1;
              s_d.retcnt  = s_q.retcnt + 8'h01;
              if (instr_i.op == rse_pkg::RSE_OP_INT_RETURN) begin
                s_d.restore    = 1'b1;
                s_d.ctx        = s_q.shadow;
                // a snapshot taken in the same cycle wins over the clear
                s_d.shadow_vld = int_take_i;
              end else begin
                s_d.st = rse_pkg::RSE_ST_RET2;
              end
            end
            rse_pkg::RSE_OP_BIT_SET: begin
              // read-modify-write of the one nibble only
              s_d.mem_wr    = 1'b1;
              s_d.mem_addr  = dp_addr_i;
              s_d.mem_wdata = set_nib;
            end
            rse_pkg::RSE_OP_CARRY_SET: begin
              s_d.carry_set = 1'b1;
            end
            default: begin
            end
          endcase
        end
      end
      rse_pkg::RSE_ST_RET2: begin
        // second machine cycle ends with an unconditional skip
        s_d.skip = 1'b1;
        s_d.st   = rse_pkg::RSE_ST_IDLE;
      end
      default: begin
        s_d.st = rse_pkg::RSE_ST_IDLE;
      end
    endcase

    // register writes; a write never races an instruction on a flag
    if (bus_i.wr) begin
      if (bus_i.addr == rse_pkg::CTRL_OFF) begin
        s_d.en = bus_i.wdata[rse_pkg::CTRL_EN_BIT];
      end
    end

    if (bus_i.rd) begin
      if (bus_i.addr == rse_pkg::CTRL_OFF) begin
        s_d.rdata[rse_pkg::CTRL_EN_BIT] = s_q.en;
      end else if (bus_i.addr == rse_pkg::STATUS_OFF) begin
        s_d.rdata[rse_pkg::STAT_SP_LSB +: rse_pkg::SP_W] = s_q.sp;
        s_d.rdata[rse_pkg::STAT_BUSY_BIT]   = !instr_ready_o;
        s_d.rdata[rse_pkg::STAT_SHADOW_BIT] = s_q.shadow_vld;
      end else if (bus_i.addr == rse_pkg::RETCNT_OFF) begin
        s_d.rdata[rse_pkg::RETCNT_W-1:0] = s_q.retcnt;
      end else begin
        s_d.rdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q        <= '0;
      s_q.st     <= rse_pkg::RSE_ST_IDLE;
      s_q.sp     <= rse_pkg::SP_RST;
      s_q.en     <= rse_pkg::EN_RST;
      s_q.retcnt <= rse_pkg::RETCNT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign pc_load_o   = s_q.pc_load;
  assign pc_o        = s_q.pc;
  assign skip_next_o = s_q.skip;
  assign restore_o   = s_q.restore;
  assign ctx_o       = s_q.ctx;
  assign carry_set_o = s_q.carry_set;
  assign mem_wr_o    = s_q.mem_wr;
  assign mem_addr_o  = s_q.mem_addr;
  assign mem_wdata_o = s_q.mem_wdata;
  assign bus_rdata_o = s_q.rdata;

  // checks

  ret_pop_pc_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    take && !push_i && (instr_i.op == rse_pkg::RSE_OP_INT_RETURN ||
                        instr_i.op == rse_pkg::RSE_OP_RETURN_SKIP)
    |=> pc_load_o && pc_o == $past(s_q.stk[s_q.sp]))
    else $error("return did not load pc from stack top");

  ret_sp_dec_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    take && !push_i && (instr_i.op == rse_pkg::RSE_OP_INT_RETURN ||
                        instr_i.op == rse_pkg::RSE_OP_RETURN_SKIP)
    |=> s_q.sp == $past(s_q.sp) - 3'h1)
    else $error("return did not decrement stack pointer");

  ctx_restore_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    take && !int_take_i && instr_i.op == rse_pkg::RSE_OP_INT_RETURN
    |=> restore_o && ctx_o == $past(s_q.shadow) && instr_ready_o)
    else $error("interrupt return context mismatch");

  acc_restore_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    take && instr_i.op == rse_pkg::RSE_OP_INT_RETURN
    |=> ctx_o.acc == $past(s_q.shadow.acc) &&
        ctx_o.aux == $past(s_q.shadow.aux))
    else $error("accumulator or auxiliary not restored");

  skip_two_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    take && instr_i.op == rse_pkg::RSE_OP_RETURN_SKIP
    |=> !instr_ready_o && !skip_next_o ##1 skip_next_o && instr_ready_o)
    else $error("return-and-skip timing wrong");

  bit_set_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    take && instr_i.op == rse_pkg::RSE_OP_BIT_SET
    |=> mem_wr_o && mem_wdata_o[$past(instr_i.imm[1:0])])
    else $error("selected bit not set");

  bit_keep_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    take && instr_i.op == rse_pkg::RSE_OP_BIT_SET
    |=> mem_addr_o == $past(dp_addr_i) &&
        ((mem_wdata_o ^ $past(mem_rdata_i)) &
         ~(4'h1 << $past(instr_i.imm[1:0]))) == 4'h0)
    else $error("bit set disturbed other bits");

  carry_one_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    take && instr_i.op == rse_pkg::RSE_OP_CARRY_SET
    |=> carry_set_o && !skip_next_o && instr_ready_o && !mem_wr_o)
    else $error("carry set misbehaved");

  shadow_grab_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    int_take_i |=> s_q.shadow == $past(ctx_i) && s_q.shadow_vld)
    else $error("interrupt snapshot not captured");

  restore_only_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    restore_o |-> $past(take && instr_i.op == rse_pkg::RSE_OP_INT_RETURN))
    else $error("context restored without interrupt return");

  ctx_hold_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    !restore_o |-> ctx_o == $past(ctx_o))
    else $error("restored context changed without a restore");

  // the pop is only as good as the push that filled the slot
  push_store_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    push_i |=> s_q.stk[s_q.sp] == $past(push_pc_i) &&
               s_q.sp == $past(s_q.sp) + 3'h1)
    else $error("push did not store pc at the new top");

  sp_hold_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    !push_i && !take |=> s_q.sp == $past(s_q.sp))
    else $error("stack pointer moved without push or return");

  pc_only_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    pc_load_o |-> $past(take && (instr_i.op == rse_pkg::RSE_OP_INT_RETURN ||
                                 instr_i.op == rse_pkg::RSE_OP_RETURN_SKIP)))
    else $error("pc loaded without a return");

  skip_only_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    skip_next_o |-> $past(s_q.st == rse_pkg::RSE_ST_RET2))
    else $error("skip without a return-and-skip");

  skip_once_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    skip_next_o |=> !skip_next_o)
    else $error("skip held for more than one cycle");

  // the stall cycle must not accept anything, or a second op slips in
  ret2_refuse_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    !instr_ready_o |=> !pc_load_o && !restore_o && !carry_set_o &&
                       !mem_wr_o)
    else $error("instruction taken during the stall cycle");

  bit_set_only_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    mem_wr_o |-> $past(take && instr_i.op == rse_pkg::RSE_OP_BIT_SET))
    else $error("memory written without a bit set");

  mem_hold_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    !mem_wr_o |-> mem_addr_o == $past(mem_addr_o) &&
                  mem_wdata_o == $past(mem_wdata_o))
    else $error("memory outputs changed without a write");

  carry_only_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    carry_set_o |-> $past(take && instr_i.op == rse_pkg::RSE_OP_CARRY_SET))
    else $error("carry set without a carry set instruction");

endmodule // rse_return_set_exec

// ---- test/rse_return_set_exec_tb.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end

module rse_return_set_exec_tb;
  logic                            core_clk_i;
  logic                            rst_i;
  rse_pkg::rse_instr_s             instr_i;
  logic                            instr_ready_o;
  logic                            push_i;
  logic [rse_pkg::PC_W-1:0]        push_pc_i;
  logic                            int_take_i;
  rse_pkg::rse_ctx_s               ctx_i;
  logic                            pc_load_o;
  logic [rse_pkg::PC_W-1:0]        pc_o;
  logic                            skip_next_o;
  logic                            restore_o;
  rse_pkg::rse_ctx_s               ctx_o;
  logic                            carry_set_o;
  logic [9:0]                      dp_addr_i;
  logic [rse_pkg::NIB_W-1:0]       mem_rdata_i;
  logic                            mem_wr_o;
  logic [9:0]                      mem_addr_o;
  logic [rse_pkg::NIB_W-1:0]       mem_wdata_o;
  rse_pkg::rse_bus_s               bus_i;
  logic [31:0]                     bus_rdata_o;
  logic [31:0]                     rd_q;
  int                              bad_count;
  int                              compares;

  rse_return_set_exec rse_return_set_exec_inst (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .instr_i(instr_i),
    .instr_ready_o(instr_ready_o), .push_i(push_i), .push_pc_i(push_pc_i),
    .int_take_i(int_take_i), .ctx_i(ctx_i), .pc_load_o(pc_load_o),
    .pc_o(pc_o), .skip_next_o(skip_next_o), .restore_o(restore_o),
    .ctx_o(ctx_o), .carry_set_o(carry_set_o), .dp_addr_i(dp_addr_i),
    .mem_rdata_i(mem_rdata_i), .mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .bus_i(bus_i), .bus_rdata_o(bus_rdata_o)
  );

  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  task automatic test_done();
    $display("mismatches %0d, comparisons %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk_i);
    bus_i <= '0;
  endtask

  // read data live only in the cycle after the strobe
  task automatic bus_rd(input logic [3:0] a);
    @(posedge core_clk_i);
    bus_i <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk_i);
    bus_i <= '0;
    #1;
    rd_q = bus_rdata_o;
  endtask

  // leaves the caller one step after the take edge, in cycle c1
  task automatic issue(input rse_pkg::rse_op_e op, input logic [3:0] imm);
    @(posedge core_clk_i);
    instr_i <= '{valid: 1'b1, op: op, imm: imm};
    @(posedge core_clk_i);
    instr_i <= '0;
    #1;
  endtask

  task automatic push(input logic [rse_pkg::PC_W-1:0] pc);
    @(posedge core_clk_i);
    push_i    <= 1'b1;
    push_pc_i <= pc;
    @(posedge core_clk_i);
    push_i    <= 1'b0;
  endtask

  task automatic test_reset();
    `CHK(instr_ready_o, 1'b1)
    bus_rd(rse_pkg::CTRL_OFF);
    `CHK(rd_q[0], rse_pkg::EN_RST)
    bus_rd(rse_pkg::STATUS_OFF);
    `CHK(rd_q[2:0], rse_pkg::SP_RST)
  endtask

  task automatic test_int_return();
    push(13'h0123);
    push(13'h1abc);
    @(posedge core_clk_i);
    int_take_i <= 1'b1;
    ctx_i      <= '{4'h3, 4'hc, 2'h2, 1'b1, 1'b1, 1'b0, 4'h9, 4'h6};
    @(posedge core_clk_i);
    int_take_i <= 1'b0;
    ctx_i      <= '0;
    bus_rd(rse_pkg::STATUS_OFF);
    `CHK(rd_q[5:0], 6'h22)
    issue(rse_pkg::RSE_OP_INT_RETURN, 4'h0);
    `CHK(pc_load_o, 1'b1)
    `CHK(pc_o, 13'h1abc)
    `CHK(restore_o, 1'b1)
    `CHK(ctx_o, {4'h3, 4'hc, 2'h2, 1'h1, 1'h1, 1'h0, 4'h9, 4'h6})
    `CHK({ctx_o.acc, ctx_o.aux}, 8'h96)
    bus_rd(rse_pkg::STATUS_OFF);
    `CHK(rd_q[5:0], 6'h01)
  endtask

  // a carry set offered in the stall cycle must be refused
  task automatic test_return_skip();
    @(posedge core_clk_i);
    instr_i <= '{valid: 1'b1, op: rse_pkg::RSE_OP_RETURN_SKIP, imm: 4'h0};
    @(posedge core_clk_i);
    instr_i <= '{valid: 1'b1, op: rse_pkg::RSE_OP_CARRY_SET, imm: 4'h0};
    #1;
    `CHK(pc_o, 13'h0123)
    `CHK({pc_load_o, instr_ready_o, skip_next_o}, 3'b100)
    @(posedge core_clk_i);
    instr_i <= '0;
    #1;
    `CHK({pc_load_o, instr_ready_o, skip_next_o}, 3'b011)
    `CHK(carry_set_o, 1'b0)
    bus_rd(rse_pkg::STATUS_OFF);
    `CHK(rd_q[2:0], 3'h0)
    bus_rd(rse_pkg::RETCNT_OFF);
    `CHK(rd_q[7:0], 8'h02)
  endtask

  task automatic test_bit_set();
    logic [3:0] nib;
    for (int j = 0; j < 4; j++) begin
      nib = 4'ha >> j;
      @(posedge core_clk_i);
      dp_addr_i   <= 10'h2c5 + 10'(j);
      mem_rdata_i <= nib;
      issue(rse_pkg::RSE_OP_BIT_SET, {2'b11, 2'(j)});
      `CHK(mem_wr_o, 1'b1)
      `CHK(mem_addr_o, 10'h2c5 + 10'(j))
      `CHK(mem_wdata_o, nib | (4'h1 << j))
    end
  endtask

  task automatic test_carry_set();
    issue(rse_pkg::RSE_OP_CARRY_SET, 4'h0);
    `CHK({carry_set_o, skip_next_o, pc_load_o}, 3'b100)
    @(posedge core_clk_i);
    #1;
    `CHK({carry_set_o, skip_next_o, instr_ready_o}, 3'b001)
  endtask

  // disabled core must ignore the request; unmapped reads give zero
  task automatic test_disable();
    bus_wr(rse_pkg::CTRL_OFF, 32'h0000_0000);
    issue(rse_pkg::RSE_OP_CARRY_SET, 4'h0);
    `CHK(carry_set_o, 1'b0)
    bus_wr(rse_pkg::CTRL_OFF, 32'h0000_0001);
    bus_rd(4'hc);
    `CHK(rd_q, 32'h0000_0000)
  endtask

  initial begin
    bad_count   = 0;
    compares    = 0;
    rst_i       = 1'b1;
    instr_i     = '0;
    push_i      = 1'b0;
    push_pc_i   = '0;
    int_take_i  = 1'b0;
    ctx_i       = '0;
    dp_addr_i   = '0;
    mem_rdata_i = '0;
    bus_i       = '0;
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'b0;
    test_reset();
    test_int_return();
    test_return_skip();
    test_bit_set();
    test_carry_set();
    test_disable();
    test_done();
  end

  // cuts a hang short
  initial begin
    repeat (2000) @(posedge core_clk_i);
    bad_count++;
    test_done();
  end
endmodule // rse_return_set_exec_tb
